// *** src/smc_pkg.sv ***
// shared constants and carriers for the supply mode control block
package smc_pkg;

	// register index as printed; the bus sees it one word per index
	localparam logic [31:0] MODE_CTRL_INDEX = 32'h0000_ff01;
	localparam logic [31:0] MODE_CTRL_ADDR = MODE_CTRL_INDEX << 2;

	// field positions inside the control word
	localparam int BOOST_EN_BIT = 0;
	localparam int UNUSED_BIT = 1;
	localparam int REG_SEL_BIT = 2;
	localparam int CONV_SEL_BIT = 3;
	localparam int CTRL_WIDTH = 4;

	// reset value: booster off, both circuits on the external supply
	localparam logic [3:0] MODE_CTRL_RESET = 4'h0;

	// bus encodings used by the slave
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;

	// settling time that software must leave after enabling the booster;
	// kept here for software and bench, hardware does not enforce it
	localparam int BOOST_SETTLE_MS = 100;
	localparam int CLK_HZ = 40000000;
	localparam longint BOOST_SETTLE_CYCLES =
		(longint'(BOOST_SETTLE_MS) * CLK_HZ + 999) / 1000;

	// data phase captured from a taken address phase
	typedef struct packed {
		logic active;
		logic write;
		logic hit;
	} smc_dphase_t;

	// stored control state driven out to the analog circuits
	typedef struct packed {
		logic converter_supply_select;
		logic regulator_supply_select;
		logic booster_enable;
	} smc_mode_t;

endpackage : smc_pkg

// *** src/smc_ahb_port.sv ***
`timescale 1ns/10ps
// address phase capture for a zero wait state AHB-Lite slave
module smc_ahb_port
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// address phase
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	// captured data phase
	output smc_pkg::smc_dphase_t dphase
);

	smc_pkg::smc_dphase_t next_dphase;

	// a transfer is taken only when the bus is ready and it is a real one;
	// idle and busy cycles leave nothing pending
	always_comb
	begin
		next_dphase.active = hsel && hready && htrans[1];
		next_dphase.write = hwrite;
		next_dphase.hit = (haddr == smc_pkg::MODE_CTRL_ADDR)
			&& (hsize == smc_pkg::HSIZE_WORD);
	end

	// register the phase; a stalled bus keeps the previous capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dphase <= '0;
		else if (hready)
			dphase <= next_dphase;
	end

endmodule : smc_ahb_port

// *** src/smc_supply_mode_control.sv ***
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
// Overview of operation
// RULE_01: control bit 0 switches the booster on or off and reads back.
// RULE_02: bit 2 puts the oscillation regulator on the boosted supply.
// RULE_03: bit 3 puts the converter control circuit on the boosted supply.
// RULE_04: reset clears booster enable and both supply selects to zero.
// RULE_05: bit 1 is unimplemented, reads zero, ignores writes.
// RULE_06: software enables booster, waits settling time, then selects boost.
// RULE_07: software clears supply select first, booster enable afterwards.
// RULE_08: booster stays on while any supply select remains set; the code lets a write clear bit 0 anyway.
// RULE_09: at very low supply software keeps the regulator boosted.
// RULE_10: at low supply software boosts converter control, else not.
// RULE_11: regulator boost at higher supply only on a detected supply drop.
// RULE_12: no interlock or ready flag; each write takes effect at once.
module smc_supply_mode_control
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// supply mode controls to the analog circuits
	output logic booster_enable,
	output logic regulator_supply_select,
	output logic converter_supply_select
);

	// captured data phase and the stored control fields
	smc_pkg::smc_dphase_t dphase;
	smc_pkg::smc_mode_t mode;

	// one flip-flop per control field
	logic booster_on;
	logic regulator_boosted;
	logic converter_boosted;

	// write and read decode
	logic ctrl_write;
	logic addr_read_hit;

	// field values of the word being written
	smc_pkg::smc_mode_t wr_fields;

	// values the fields take at the coming edge
	logic next_booster_enable;
	logic next_regulator_supply_select;
	logic next_converter_supply_select;
	smc_pkg::smc_mode_t next_mode;

	// readable image and the read data register input
	logic [3:0] next_view;
	logic [31:0] next_hrdata;

	// address phase capture
	smc_ahb_port u_port
	(
		.hclk (hclk),
		.hresetn (hresetn),
		.hsel (hsel),
		.haddr (haddr),
		.htrans (htrans),
		.hwrite (hwrite),
		.hsize (hsize),
		.hready (hready),
		.dphase (dphase)
	);

	// zero wait states and always OKAY; nothing here can fail a transfer,
	// so the bus never has to be held off or answered with an error
	assign hreadyout = 1'b1;
	assign hresp = smc_pkg::HRESP_OKAY;

	// a write lands only when its captured data phase hit the register;
	// idle cycles, reads and misses all leave the stored bits alone
	always_comb
	begin
		if (!dphase.active)
		begin
			ctrl_write = 1'b0;
		end
		else if (!dphase.write)
		begin
			ctrl_write = 1'b0;
		end
		else if (!dphase.hit)
		begin
			ctrl_write = 1'b0;
		end
		else
		begin
			ctrl_write = 1'b1;
		end
	end

	// a read is recognised in its address phase, so that the read data
	// flip-flop can be loaded at the edge that opens the data phase;
	// a non-word size or another address is a miss and reads as zero
	always_comb
	begin
		if (!(hsel && hready && htrans[1]))
		begin
			addr_read_hit = 1'b0;
		end
		else if (hwrite)
		begin
			addr_read_hit = 1'b0;
		end
		else if (haddr != smc_pkg::MODE_CTRL_ADDR)
		begin
			addr_read_hit = 1'b0;
		end
		else if (hsize != smc_pkg::HSIZE_WORD)
		begin
			addr_read_hit = 1'b0;
		end
		else
		begin
			addr_read_hit = 1'b1;
		end
	end

	// split the write word into the three stored fields; bit 1 has no
	// storage, so whatever software writes there is simply dropped
	always_comb
	begin
		wr_fields.booster_enable = hwdata[smc_pkg::BOOST_EN_BIT];
		wr_fields.regulator_supply_select =
			hwdata[smc_pkg::REG_SEL_BIT];
		wr_fields.converter_supply_select =
			hwdata[smc_pkg::CONV_SEL_BIT];
	end

	// RULE_01 booster on or off
	// the booster follows each landing write at once; there is no
	// check against the supply selects, software owns that ordering
	always_comb
	begin
		if (ctrl_write)
		begin
			next_booster_enable = wr_fields.booster_enable;
		end
		else
		begin
			next_booster_enable = mode.booster_enable;
		end
	end

	// RULE_02 regulator supply select
	// the regulator moves to the boosted supply on the write itself,
	// even if the booster has not yet had time to settle
	always_comb
	begin
		if (ctrl_write)
		begin
			next_regulator_supply_select =
				wr_fields.regulator_supply_select;
		end
		else
		begin
			next_regulator_supply_select =
				mode.regulator_supply_select;
		end
	end

	// RULE_03 converter supply select
	// independent of the regulator select; both share the one booster
	always_comb
	begin
		if (ctrl_write)
		begin
			next_converter_supply_select =
				wr_fields.converter_supply_select;
		end
		else
		begin
			next_converter_supply_select =
				mode.converter_supply_select;
		end
	end

	// RULE_12 immediate write effect
	// no hold-off and no ready flag for settling: a lockout here would
	// need a counter of millions of cycles, which software timing avoids
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			// RULE_04 reset clears all
			booster_on <=
				smc_pkg::MODE_CTRL_RESET[smc_pkg::BOOST_EN_BIT];
		end
		else
		begin
			booster_on <= next_booster_enable;
		end
	end

	// regulator select store; reset puts it on the external supply
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			regulator_boosted <=
				smc_pkg::MODE_CTRL_RESET[smc_pkg::REG_SEL_BIT];
		end
		else
		begin
			regulator_boosted <= next_regulator_supply_select;
		end
	end

	// converter select store; reset puts it on the external supply
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			converter_boosted <=
				smc_pkg::MODE_CTRL_RESET[smc_pkg::CONV_SEL_BIT];
		end
		else
		begin
			converter_boosted <= next_converter_supply_select;
		end
	end

	// the stored fields as one carrier for the readback and the outputs
	always_comb
	begin
		mode.booster_enable = booster_on;
		mode.regulator_supply_select = regulator_boosted;
		mode.converter_supply_select = converter_boosted;
	end

	// pack a set of fields into the readable nibble;
	// bits 31:4 are filled with zero by the caller
	function automatic logic [3:0] read_image
	(
		input smc_pkg::smc_mode_t fields
	);
		logic [3:0] image;
		image = '0;
		image[smc_pkg::BOOST_EN_BIT] = fields.booster_enable;
		image[smc_pkg::REG_SEL_BIT] = fields.regulator_supply_select;
		image[smc_pkg::CONV_SEL_BIT] = fields.converter_supply_select;
		// RULE_05 unused bit reads zero
		image[smc_pkg::UNUSED_BIT] = 1'b0;
		return image;
	endfunction : read_image

	// the word as it stands after this edge; a read whose address phase
	// meets the data phase of a write therefore sees the new value
	always_comb
	begin
		next_mode.booster_enable = next_booster_enable;
		next_mode.regulator_supply_select =
			next_regulator_supply_select;
		next_mode.converter_supply_select =
			next_converter_supply_select;
		next_view = read_image(next_mode);
	end

	// read data word: the nibble on a hit, zero on a miss or no read
	always_comb
	begin
		if (addr_read_hit)
		begin
			next_hrdata = {28'h000_0000, next_view};
		end
		else
		begin
			next_hrdata = 32'h0000_0000; // unmapped or idle reads zero
		end
	end

	// read data from a flip-flop, loaded as the data phase opens; it stands
	// for exactly that data phase and then takes the next read's word, or zero
	// if no read hit follows, and a stalled bus keeps it where it is
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h0000_0000;
		end
		else if (hready)
		begin
			hrdata <= next_hrdata;
		end
	end

	// controls go out unchanged; the analog side owns the settling
	always_comb
	begin
		booster_enable = mode.booster_enable;
		regulator_supply_select = mode.regulator_supply_select;
		converter_supply_select = mode.converter_supply_select;
	end

endmodule : smc_supply_mode_control

// *** bench/smc_supply_mode_control_properties.sv ***
`timescale 1ns/10ps
module smc_props
(
	// bus and supply controls
	input wire logic hclk, hresetn, hsel, hwrite, booster_enable,
	input wire logic regulator_supply_select, converter_supply_select,
	input wire logic hready, hreadyout, hresp,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic [31:0] haddr, hwdata, hrdata
);
	logic [1:0] ph;
	wire [2:0] m = {converter_supply_select, regulator_supply_select,
		booster_enable};
	wire hit = hsel && hready && htrans[1] &&
		haddr == smc_pkg::MODE_CTRL_ADDR && hsize == smc_pkg::HSIZE_WORD;
	// hit phase kind
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			ph <= 2'h0;
		else
			ph <= {hit && hwrite, hit && !hwrite};
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bits_stored: assert property (ph[1] |=>
		m == {$past(hwdata[3:2]), $past(hwdata[0])}) else $error("bits");
	a_read_image: assert property (ph[0] |->
		hrdata == {28'h0, m[2:1], 1'h0, m[0]}) else $error("read");
	a_write_only: assert property (!ph[1] |=>
		$stable(m)) else $error("change");
	a_zero_wait: assert property (hreadyout) else $error("wait");
	a_resp_okay: assert property (hresp == smc_pkg::HRESP_OKAY)
		else $error("resp");
	a_upper_zero: assert property (hrdata[31:4] == 28'h0 && !hrdata[1])
		else $error("upper");
	a_idle_read: assert property (!ph[0] |-> hrdata == 32'h0)
		else $error("idle");
endmodule : smc_props
bind smc_supply_mode_control smc_props u_props (.*);

// *** bench/smc_supply_mode_control_test.sv ***
`timescale 1ns/10ps
module smc_supply_mode_control_test;
	localparam A = smc_pkg::MODE_CTRL_ADDR;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdy, b, r, c, rs;
	logic [2:0] sz = 3'h2;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, q;
	int err_total, comparisons;
	always #12.5 hclk = ~hclk;
	smc_supply_mode_control DUT (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(sz), .hwdata, .hready(rdy), .hreadyout(rdy),
		.hresp(rs), .hrdata(rd), .booster_enable(b),
		.regulator_supply_select(r), .converter_supply_select(c));
	task chk(input string n, input logic [34:0] s, e);
		comparisons++;
		if (s !== e)
			$display("wrong value %s exp %h seen %h", n, e, s);
		err_total += (s !== e);
	endtask : chk
	// read data is taken at the closing edge, before the slave moves on
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk) {hsel, hwrite, htrans, haddr} <= {1'h1, w, 2'h2, a};
		@(posedge hclk iff rdy);
		{hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
		@(posedge hclk iff rdy);
		q = rd;
	endtask : bus
	task t_fields;
		for (int i = 0; i < 16; i++)
		begin
			bus(A, 1'h1, i);
			bus(A, 1'h0, 32'h0);
			chk("field", {c, r, 1'h0, b, q[3:0]}, {2{4'(i) & 4'hd}});
			chk("okay", {rs, rdy}, 35'h1);
		end
		$display("fields done");
	endtask : t_fields
	task t_modes;
		bus(A, 1'h1, 32'h1);
		repeat (100) @(posedge hclk);
		bus(A, 1'h1, 32'hd);
		bus(A, 1'h1, 32'h1);
		bus(A, 1'h0, 32'h0);
		chk("select off", {c, r, b, q[3:0]}, 35'h11);
		bus(A, 1'h1, 32'h5);
		bus(A, 1'h0, 32'h0);
		chk("drop boost", {c, r, b, q[3:0]}, 35'h35);
		bus(A, 1'h1, 32'h1);
		bus(A + 4, 1'h1, 32'hd);
		sz <= 3'h1;
		bus(A, 1'h1, 32'hd);
		sz <= 3'h2;
		bus(A + 4, 1'h0, 32'h0);
		chk("unmapped", {c, r, b, q}, 35'h1_0000_0000);
		bus(A, 1'h1, 32'h0);
		bus(A, 1'h0, 32'h0);
		chk("booster off", {c, r, b, q[3:0]}, 35'h0);
		bus(A, 1'h1, 32'hf);
		@(posedge hclk) hresetn <= 1'h0;
		#1 chk("reset", {c, r, b}, 35'h0);
		@(posedge hclk) hresetn <= 1'h1;
		bus(A, 1'h0, 32'h0);
		chk("reset read", q, 35'h0);
		$display("modes done");
	endtask : t_modes
	task final_report;
		$display("checks %0d errors %0d", comparisons, err_total);
		if (!err_total && comparisons)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		t_fields;
		t_modes;
		final_report;
	end
	// watchdog
	initial
	begin
		#50000 err_total++;
		final_report;
	end
endmodule : smc_supply_mode_control_test
